// ### verilog/gxp_pkg.sv
package gxp_pkg;

  localparam int NUM_PINS = 16;
  localparam int BANK_W = 8;

  // Pointer values of the base and extended register sets
  localparam logic [7:0] PTR_IN0 = 8'h00;
  localparam logic [7:0] PTR_IN1 = 8'h01;
  localparam logic [7:0] PTR_OUT0 = 8'h02;
  localparam logic [7:0] PTR_OUT1 = 8'h03;
  localparam logic [7:0] PTR_POL0 = 8'h04;
  localparam logic [7:0] PTR_POL1 = 8'h05;
  localparam logic [7:0] PTR_CFG0 = 8'h06;
  localparam logic [7:0] PTR_CFG1 = 8'h07;
  localparam logic [7:0] PTR_DRV0A = 8'h40;
  localparam logic [7:0] PTR_DRV0B = 8'h41;
  localparam logic [7:0] PTR_DRV1A = 8'h42;
  localparam logic [7:0] PTR_DRV1B = 8'h43;
  localparam logic [7:0] PTR_LAT0 = 8'h44;
  localparam logic [7:0] PTR_LAT1 = 8'h45;
  localparam logic [7:0] PTR_PEN0 = 8'h46;
  localparam logic [7:0] PTR_PEN1 = 8'h47;
  localparam logic [7:0] PTR_PSEL0 = 8'h48;
  localparam logic [7:0] PTR_PSEL1 = 8'h49;
  localparam logic [7:0] PTR_MASK0 = 8'h4a;
  localparam logic [7:0] PTR_MASK1 = 8'h4b;
  localparam logic [7:0] PTR_ISTAT0 = 8'h4c;
  localparam logic [7:0] PTR_ISTAT1 = 8'h4d;
  localparam logic [7:0] PTR_OPCFG = 8'h4f;
  localparam int PTR_EXT_BIT = 6;

  // Reset values
  localparam logic [15:0] RST_OUT = 16'hffff;
  localparam logic [15:0] RST_POL = 16'h0000;
  localparam logic [15:0] RST_CFG = 16'hffff;
  localparam logic [31:0] RST_DRV = 32'hffffffff;
  localparam logic [15:0] RST_LAT = 16'h0000;
  localparam logic [15:0] RST_PEN = 16'hffff;
  localparam logic [15:0] RST_PSEL = 16'hffff;
  localparam logic [15:0] RST_MASK = 16'hffff;
  localparam logic [1:0] RST_OPCFG = 2'h0;
  localparam logic [7:0] RST_PTR = 8'h00;

  // Fixed upper part of the slave address; arbitrary default
  localparam logic [3:0] SLAVE_ADDR_HI = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD, ST_WR, ST_ACK_WR, ST_RD, ST_RD_ACK
  } gxp_state_e;

  // Per-pin pad controls that do not take part in the pin data path
  typedef struct packed {
    logic [31:0] drive;
    logic [15:0] pull_en;
    logic [15:0] pull_up;
  } gxp_pad_s;

endpackage

// ### verilog/gxp_expander.sv
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Interrupt asserts while any unmasked pin differs from its input register value.
// RULE_02: All interrupt mask bits reset to masked.
// RULE_03: Reset loads every register default and returns the bus state machine to idle.
// RULE_04: Slave address low three bits come from the three address select pins.
// RULE_05: After reset all pins are inputs with pull resistor enabled pulling up.
// RULE_06: Interrupt pin is open drain, active low.
// RULE_07: Each bank selects push-pull or open-drain output stages.
// RULE_08: Read-only interrupt status shows which pins cause the interrupt.
// RULE_09: Each output bit has a two-bit, four-level drive strength setting.
// RULE_10: With latching on, a captured input change holds until the input register is read.
// RULE_11: Per-pin enable connects the pull resistor or leaves the input floating.
// RULE_12: Per-pin select chooses pull-up or pull-down.
// RULE_13: Per-pin mask bit blocks that pin from raising the interrupt.
// RULE_14: Base set is input, output, polarity and direction registers, one per port.
// RULE_15: Sixteen pins in two eight-bit banks.
// RULE_16: Output values are held and driven until rewritten.
// RULE_17: Byte after the address is a write-only pointer selecting the data register.
// RULE_18: Input registers follow pins in any direction; writes to them are ignored.
// RULE_19: Last address bit one means read, zero means write.
// RULE_20: Pointer bit 6 with the low four bits selects the extended registers.
// RULE_21: Polarity inversion bit inverts the value returned in the input register.
module gxp_expander (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe_b,
  output logic o_sda,
  input wire logic i_addr_select_bit0,
  input wire logic i_addr_select_bit1,
  input wire logic i_addr_select_bit2,
  input wire logic [7:0] i_bank_zero_pins,
  output logic [7:0] o_bank_zero_pins,
  output logic [7:0] o_bank_zero_pins_oe_b,
  input wire logic [7:0] i_bank_one_pins,
  output logic [7:0] o_bank_one_pins,
  output logic [7:0] o_bank_one_pins_oe_b,
  output logic o_int_oe_b,
  output logic o_int,
  output gxp_pkg::gxp_pad_s o_pad_cfg
);

  // Two-of-three agreement filter on a synchronised input
  function automatic logic [15:0] agree(input logic [15:0] s2, input logic [15:0] s3, input logic [15:0] cur);
    agree = (s2 & s3) | (cur & (s2 ^ s3));
  endfunction

  gxp_pkg::gxp_state_e state_r;
  logic [2:0] scl_s_r, sda_s_r, asel_s1_r, asel_s2_r, asel_s3_r;
  logic scl_f_r, sda_f_r, scl_d_r, sda_d_r;
  logic [2:0] asel_f_r;
  logic [15:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r, tx_r, ptr_r;
  logic rw_r, nack_r;
  logic [15:0] out_r, pol_r, cfg_r, lat_r, pen_r, psel_r, mask_r;
  logic [31:0] drv_r;
  logic [1:0] opcfg_r;
  logic [15:0] snap_r, lat_val_r, pend_r, istat_r;
  logic scl_rise, scl_fall, start_det, stop_det, wr_en, rd_load;
  logic [15:0] in_val, in_rd, diff, asel_agree;
  logic [7:0] rd_data;

  // Bus and pin synchronisers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], i_scl};
      sda_s_r <= {sda_s_r[1:0], i_sda};
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_s1_r <= 16'h0000;
      pin_s2_r <= 16'h0000;
      pin_s3_r <= 16'h0000;
      pin_f_r <= 16'h0000;
      asel_s1_r <= 3'h0;
      asel_s2_r <= 3'h0;
      asel_s3_r <= 3'h0;
      asel_f_r <= 3'h0;
    end else begin
      pin_s1_r <= {i_bank_one_pins, i_bank_zero_pins};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_f_r <= agree(pin_s2_r, pin_s3_r, pin_f_r);
      asel_s1_r <= {i_addr_select_bit2, i_addr_select_bit1, i_addr_select_bit0};
      asel_s2_r <= asel_s1_r;
      asel_s3_r <= asel_s2_r;
      asel_f_r <= asel_agree[2:0]; // RULE_04
    end
  end

  assign asel_agree = agree({13'h0000, asel_s2_r}, {13'h0000, asel_s3_r}, {13'h0000, asel_f_r});
  assign scl_rise = scl_f_r & ~scl_d_r;
  assign scl_fall = ~scl_f_r & scl_d_r;
  assign start_det = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
  assign stop_det = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;
  assign wr_en = (state_r == gxp_pkg::ST_WR) & scl_fall & (bitcnt_r == gxp_pkg::BITS_PER_BYTE);
  assign rd_load = scl_fall & (((state_r == gxp_pkg::ST_ACK_ADDR) & rw_r) | ((state_r == gxp_pkg::ST_RD_ACK) & ~nack_r));

  assign in_val = pin_f_r ^ pol_r; // RULE_18 RULE_21
  assign in_rd = (pend_r & lat_val_r) | (~pend_r & in_val); // RULE_10
  assign diff = in_val ^ snap_r;

  // Register read decode; unmapped pointers read zero
  always_comb begin
    case (ptr_r)
      gxp_pkg::PTR_IN0: rd_data = in_rd[7:0];
      gxp_pkg::PTR_IN1: rd_data = in_rd[15:8];
      gxp_pkg::PTR_OUT0: rd_data = out_r[7:0];
      gxp_pkg::PTR_OUT1: rd_data = out_r[15:8];
      gxp_pkg::PTR_POL0: rd_data = pol_r[7:0];
      gxp_pkg::PTR_POL1: rd_data = pol_r[15:8];
      gxp_pkg::PTR_CFG0: rd_data = cfg_r[7:0];
      gxp_pkg::PTR_CFG1: rd_data = cfg_r[15:8];
      gxp_pkg::PTR_DRV0A: rd_data = drv_r[7:0];
      gxp_pkg::PTR_DRV0B: rd_data = drv_r[15:8];
      gxp_pkg::PTR_DRV1A: rd_data = drv_r[23:16];
      gxp_pkg::PTR_DRV1B: rd_data = drv_r[31:24];
      gxp_pkg::PTR_LAT0: rd_data = lat_r[7:0];
      gxp_pkg::PTR_LAT1: rd_data = lat_r[15:8];
      gxp_pkg::PTR_PEN0: rd_data = pen_r[7:0];
      gxp_pkg::PTR_PEN1: rd_data = pen_r[15:8];
      gxp_pkg::PTR_PSEL0: rd_data = psel_r[7:0];
      gxp_pkg::PTR_PSEL1: rd_data = psel_r[15:8];
      gxp_pkg::PTR_MASK0: rd_data = mask_r[7:0];
      gxp_pkg::PTR_MASK1: rd_data = mask_r[15:8];
      gxp_pkg::PTR_ISTAT0: rd_data = istat_r[7:0]; // RULE_08 RULE_20
      gxp_pkg::PTR_ISTAT1: rd_data = istat_r[15:8];
      gxp_pkg::PTR_OPCFG: rd_data = {6'h00, opcfg_r};
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave state machine
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= gxp_pkg::ST_IDLE; // RULE_03
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= gxp_pkg::RST_PTR;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      o_sda_oe_b <= 1'b1;
    end else if (start_det) begin
      state_r <= gxp_pkg::ST_ADDR;
      bitcnt_r <= 4'h0;
      o_sda_oe_b <= 1'b1;
    end else if (stop_det) begin
      state_r <= gxp_pkg::ST_IDLE;
      o_sda_oe_b <= 1'b1;
    end else begin
      case (state_r)
        gxp_pkg::ST_ADDR, gxp_pkg::ST_CMD, gxp_pkg::ST_WR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_f_r};
            bitcnt_r <= bitcnt_r + 4'h1;
          end else if (scl_fall && bitcnt_r == gxp_pkg::BITS_PER_BYTE) begin
            o_sda_oe_b <= 1'b0;
            if (state_r == gxp_pkg::ST_ADDR) begin
              if (shift_r[7:1] == {gxp_pkg::SLAVE_ADDR_HI, asel_f_r}) begin // RULE_04
                state_r <= gxp_pkg::ST_ACK_ADDR;
                rw_r <= shift_r[0]; // RULE_19
              end else begin
                state_r <= gxp_pkg::ST_IDLE;
                o_sda_oe_b <= 1'b1;
              end
            end else if (state_r == gxp_pkg::ST_CMD) begin
              ptr_r <= shift_r; // RULE_17
              state_r <= gxp_pkg::ST_ACK_CMD;
            end else begin
              ptr_r <= {ptr_r[7:1], ~ptr_r[0]};
              state_r <= gxp_pkg::ST_ACK_WR;
            end
          end
        end
        gxp_pkg::ST_ACK_ADDR, gxp_pkg::ST_ACK_CMD, gxp_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (state_r == gxp_pkg::ST_ACK_ADDR && rw_r) begin
              tx_r <= rd_data;
              o_sda_oe_b <= rd_data[7];
              ptr_r <= {ptr_r[7:1], ~ptr_r[0]};
              state_r <= gxp_pkg::ST_RD;
            end else begin
              o_sda_oe_b <= 1'b1;
              state_r <= (state_r == gxp_pkg::ST_ACK_ADDR) ? gxp_pkg::ST_CMD : gxp_pkg::ST_WR;
            end
          end
        end
        gxp_pkg::ST_RD: begin
          if (scl_fall) begin
            bitcnt_r <= bitcnt_r + 4'h1;
            tx_r <= {tx_r[6:0], 1'b1};
            o_sda_oe_b <= (bitcnt_r == 4'h7) ? 1'b1 : tx_r[6];
            if (bitcnt_r == 4'h7) begin
              state_r <= gxp_pkg::ST_RD_ACK;
            end
          end
        end
        gxp_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            nack_r <= sda_f_r;
          end else if (scl_fall) begin
            bitcnt_r <= 4'h0;
            if (nack_r) begin
              state_r <= gxp_pkg::ST_IDLE;
            end else begin
              tx_r <= rd_data;
              o_sda_oe_b <= rd_data[7];
              ptr_r <= {ptr_r[7:1], ~ptr_r[0]};
              state_r <= gxp_pkg::ST_RD;
            end
          end
        end
        default: state_r <= gxp_pkg::ST_IDLE;
      endcase
    end
  end

  // Writable registers; input and status pointers take no write
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      out_r <= gxp_pkg::RST_OUT;
      pol_r <= gxp_pkg::RST_POL;
      cfg_r <= gxp_pkg::RST_CFG; // RULE_05
      drv_r <= gxp_pkg::RST_DRV;
      lat_r <= gxp_pkg::RST_LAT;
      pen_r <= gxp_pkg::RST_PEN; // RULE_05
      psel_r <= gxp_pkg::RST_PSEL;
      mask_r <= gxp_pkg::RST_MASK; // RULE_02
      opcfg_r <= gxp_pkg::RST_OPCFG;
    end else if (wr_en) begin
      case (ptr_r)
        gxp_pkg::PTR_OUT0: out_r[7:0] <= shift_r; // RULE_14 RULE_16
        gxp_pkg::PTR_OUT1: out_r[15:8] <= shift_r;
        gxp_pkg::PTR_POL0: pol_r[7:0] <= shift_r;
        gxp_pkg::PTR_POL1: pol_r[15:8] <= shift_r;
        gxp_pkg::PTR_CFG0: cfg_r[7:0] <= shift_r;
        gxp_pkg::PTR_CFG1: cfg_r[15:8] <= shift_r;
        gxp_pkg::PTR_DRV0A: drv_r[7:0] <= shift_r; // RULE_09
        gxp_pkg::PTR_DRV0B: drv_r[15:8] <= shift_r;
        gxp_pkg::PTR_DRV1A: drv_r[23:16] <= shift_r;
        gxp_pkg::PTR_DRV1B: drv_r[31:24] <= shift_r;
        gxp_pkg::PTR_LAT0: lat_r[7:0] <= shift_r;
        gxp_pkg::PTR_LAT1: lat_r[15:8] <= shift_r;
        gxp_pkg::PTR_PEN0: pen_r[7:0] <= shift_r; // RULE_11
        gxp_pkg::PTR_PEN1: pen_r[15:8] <= shift_r;
        gxp_pkg::PTR_PSEL0: psel_r[7:0] <= shift_r; // RULE_12
        gxp_pkg::PTR_PSEL1: psel_r[15:8] <= shift_r;
        gxp_pkg::PTR_MASK0: mask_r[7:0] <= shift_r; // RULE_13
        gxp_pkg::PTR_MASK1: mask_r[15:8] <= shift_r;
        gxp_pkg::PTR_OPCFG: opcfg_r <= shift_r[1:0]; // RULE_07
        default: opcfg_r <= opcfg_r; // RULE_18
      endcase
    end
  end

  // Change tracking: snapshot of the last value read, latched captures, status
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      snap_r <= 16'h0000;
      lat_val_r <= 16'h0000;
      pend_r <= 16'h0000;
      istat_r <= 16'h0000;
    end else begin
      for (int b = 0; b < gxp_pkg::NUM_PINS; b++) begin
        if (rd_load && ptr_r == ((b < gxp_pkg::BANK_W) ? gxp_pkg::PTR_IN0 : gxp_pkg::PTR_IN1)) begin
          snap_r[b] <= in_rd[b];
          pend_r[b] <= 1'b0; // RULE_10
        end else if (lat_r[b] && diff[b] && !pend_r[b]) begin
          lat_val_r[b] <= in_val[b];
          pend_r[b] <= 1'b1; // RULE_10
        end
      end
      istat_r <= (diff | pend_r) & ~mask_r; // RULE_01 RULE_08 RULE_13
    end
  end

  // Pin, pad and interrupt outputs, all registered
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bank_zero_pins <= 8'hff;
      o_bank_one_pins <= 8'hff;
      o_bank_zero_pins_oe_b <= 8'hff;
      o_bank_one_pins_oe_b <= 8'hff;
      o_pad_cfg <= '{drive: gxp_pkg::RST_DRV, pull_en: gxp_pkg::RST_PEN, pull_up: gxp_pkg::RST_PSEL};
      o_int_oe_b <= 1'b1;
      o_int <= 1'b0;
      o_sda <= 1'b0;
    end else begin
      o_bank_zero_pins <= out_r[7:0]; // RULE_15 RULE_16
      o_bank_one_pins <= out_r[15:8];
      // Open-drain banks release the pin for a one instead of driving it high
      o_bank_zero_pins_oe_b <= cfg_r[7:0] | ({8{opcfg_r[0]}} & out_r[7:0]); // RULE_07
      o_bank_one_pins_oe_b <= cfg_r[15:8] | ({8{opcfg_r[1]}} & out_r[15:8]);
      o_pad_cfg <= '{drive: drv_r, pull_en: pen_r, pull_up: psel_r}; // RULE_09 RULE_11 RULE_12
      o_int_oe_b <= ~|istat_r; // RULE_01 RULE_06
      o_int <= 1'b0;
      o_sda <= 1'b0;
    end
  end

endmodule

// ### testbench/gxp_expander_checker.sv
`timescale 1ns/1ps
module gxp_expander_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe_b,
  input wire logic o_sda,
  input wire logic i_addr_select_bit0,
  input wire logic i_addr_select_bit1,
  input wire logic i_addr_select_bit2,
  input wire logic [7:0] i_bank_zero_pins,
  input wire logic [7:0] o_bank_zero_pins,
  input wire logic [7:0] o_bank_zero_pins_oe_b,
  input wire logic [7:0] i_bank_one_pins,
  input wire logic [7:0] o_bank_one_pins,
  input wire logic [7:0] o_bank_one_pins_oe_b,
  input wire logic o_int_oe_b,
  input wire logic o_int,
  input wire gxp_pkg::gxp_pad_s o_pad_cfg
);
  logic [3:0] quiet_r;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  // Bus parked and pins still: nothing may move on its own
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) quiet_r <= 4'h0;
    else if (!i_scl || !$stable({i_sda, i_bank_zero_pins, i_bank_one_pins})) quiet_r <= 4'h0;
    else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
  end
  chk_int_low_only: assert property (o_int == 1'b0)
    else $error("int data not low");
  chk_rst_pins_in: assert property ($rose(i_rst_b) |-> &{o_bank_zero_pins_oe_b, o_bank_one_pins_oe_b, o_bank_zero_pins})
    else $error("pins not inputs after reset");
  chk_rst_pad_pull: assert property ($rose(i_rst_b) |->
    o_pad_cfg == {gxp_pkg::RST_DRV, gxp_pkg::RST_PEN, gxp_pkg::RST_PSEL})
    else $error("pad config wrong after reset");
  chk_rst_int_off: assert property ($rose(i_rst_b) |-> o_int_oe_b && o_sda_oe_b)
    else $error("int or sda driven after reset");
  chk_held_reset: assert property (disable iff (1'b0) !i_rst_b |->
    o_int_oe_b && o_sda_oe_b && &{o_bank_zero_pins_oe_b, o_bank_one_pins_oe_b})
    else $error("outputs driven in reset");
  chk_out_hold: assert property (quiet_r >= 4'hc |-> $stable({o_bank_zero_pins, o_bank_one_pins,
    o_bank_zero_pins_oe_b, o_bank_one_pins_oe_b}))
    else $error("pin outputs moved while idle");
  chk_pad_hold: assert property (quiet_r >= 4'hc |-> $stable(o_pad_cfg))
    else $error("pad config moved while idle");
  chk_sda_idle_free: assert property (quiet_r >= 4'hc |-> o_sda_oe_b)
    else $error("sda held on idle bus");
  chk_int_quiet: assert property (quiet_r >= 4'hc |-> $stable(o_int_oe_b))
    else $error("int moved without cause");
endmodule
bind gxp_expander gxp_expander_checker u_chk (.i_sys_clk, .i_rst_b, .i_scl, .i_sda, .o_sda_oe_b, .o_sda,
  .i_addr_select_bit0, .i_addr_select_bit1, .i_addr_select_bit2, .i_bank_zero_pins, .o_bank_zero_pins,
  .o_bank_zero_pins_oe_b, .i_bank_one_pins, .o_bank_one_pins, .o_bank_one_pins_oe_b, .o_int_oe_b, .o_int,
  .o_pad_cfg);

// ### testbench/gxp_i2c_master.sv
`timescale 1ns/1ps
module gxp_i2c_master (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  // Clock parks high between frames, data released to the pull-up
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic start;
    o_sda = 1'b1;
    #80 o_scl = 1'b1;
    #40 o_sda = 1'b0;
    #40 o_scl = 1'b0;
    #40;
  endtask
  task automatic stop;
    o_sda = 1'b0;
    #40 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #80;
  endtask
  // Data moves only mid-low so the slave never sees it change under a high clock
  // Long low phase: the slave answers about five clocks after each fall, before the next rise
  task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      #20 o_sda = tx[i];
      #60 o_scl = 1'b1;
      #20 rx[i] = i_sda;
      #20 o_scl = 1'b0;
      #40;
    end
  endtask
  task automatic unused_bits;
    for (int i = 0; i < 0; i++) begin
      #40 o_scl = 1'b1;
      #40 o_scl = 1'b0;
      #40;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input int n,
    output logic nak);
    logic [8:0] r;
    start;
    bits({a, 2'b01}, r);
    nak = r[0];
    if (!nak) begin
      bits({p, 1'b1}, r);
      for (int i = 0; i < n; i++) bits({d[8*i +: 8], 1'b1}, r);
    end
    stop;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] q);
    logic [8:0] r;
    start;
    bits({a, 2'b01}, r);
    bits({p, 1'b1}, r);
    start;
    bits({a, 2'b11}, r);
    bits(9'h1ff, r);
    q = r[8:1];
    stop;
  endtask
endmodule

// ### testbench/tb_gxp_expander.sv
`timescale 1ns/1ps
module tb_gxp_expander;
  logic clk = 1'b0;
  logic rst_b = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [7:0] p0 = 8'h00;
  logic [7:0] p1 = 8'h00;
  logic [7:0] z0, z1, e0, e1, q;
  logic sda_oe_b, sda_o, int_oe_b, int_o, scl, m_sda, nak;
  gxp_pkg::gxp_pad_s pad;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;
  wire sda = m_sda & (sda_oe_b | sda_o);
  gxp_expander dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_scl(scl), .i_sda(sda), .o_sda_oe_b(sda_oe_b),
    .o_sda(sda_o), .i_addr_select_bit0(sel[0]), .i_addr_select_bit1(sel[1]), .i_addr_select_bit2(sel[2]),
    .i_bank_zero_pins(p0), .o_bank_zero_pins(z0), .o_bank_zero_pins_oe_b(e0), .i_bank_one_pins(p1),
    .o_bank_one_pins(z1), .o_bank_one_pins_oe_b(e1), .o_int_oe_b(int_oe_b), .o_int(int_o), .o_pad_cfg(pad));
  gxp_i2c_master m (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic wrap_up;
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    m.wr({gxp_pkg::SLAVE_ADDR_HI, sel}, p, d, n, nak);
    chk(nak, 1'b0);
    w(2);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    m.rd({gxp_pkg::SLAVE_ADDR_HI, sel}, p, q);
    chk(q, exp);
    w(2);
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    w(20);
    chk({z0, z1, e0, e1, 7'h00, int_oe_b}, {32'hffffffff, 8'h01});
    chk(pad, {gxp_pkg::RST_DRV, gxp_pkg::RST_PEN, gxp_pkg::RST_PSEL});
    rst_b = 1'b1;
    w(4);
  endtask
  task automatic test_regs;
    logic [15:0] tbl [11] = '{16'h02ff, 16'h03ff, 16'h0400, 16'h06ff, 16'h40ff, 16'h4400, 16'h46ff,
      16'h48ff, 16'h4aff, 16'h4c00, 16'h4f00};
    foreach (tbl[i]) rd(tbl[i][15:8], tbl[i][7:0]);
  endtask
  task automatic test_addr;
    for (int a = 0; a < 8; a++) begin
      sel = a[2:0];
      w(8);
      m.wr({gxp_pkg::SLAVE_ADDR_HI, a[2:0]}, 8'h00, 16'h0000, 0, nak);
      chk(nak, 1'b0);
      m.wr({gxp_pkg::SLAVE_ADDR_HI, ~a[2:0]}, 8'h00, 16'h0000, 0, nak);
      chk(nak, 1'b1);
    end
  endtask
  task automatic test_out;
    wr(gxp_pkg::PTR_CFG0, 16'h0000, 2);
    wr(gxp_pkg::PTR_OUT0, 16'h3ca5, 2);
    chk({z0, z1, e0, e1}, 32'ha53c0000);
    wr(gxp_pkg::PTR_OPCFG, 16'h0001, 1);
    chk({e0, e1}, 16'ha500);
    p0 = 8'h5a;
    w(8);
    rd(gxp_pkg::PTR_IN0, 8'h5a);
    wr(gxp_pkg::PTR_IN0, 16'h00ff, 1);
    rd(gxp_pkg::PTR_IN0, 8'h5a);
    wr(gxp_pkg::PTR_POL0, 16'h000f, 1);
    rd(gxp_pkg::PTR_IN0, 8'h55);
  endtask
  task automatic test_int;
    rd(gxp_pkg::PTR_IN1, 8'h00);
    wr(gxp_pkg::PTR_MASK1, 16'h00fe, 1);
    p1 = 8'h02;
    w(10);
    chk(int_oe_b, 1'b1);
    p1 = 8'h03;
    w(10);
    chk({int_oe_b, int_o}, 2'b00);
    rd(gxp_pkg::PTR_ISTAT1, 8'h01);
    rd(gxp_pkg::PTR_IN1, 8'h03);
    w(10);
    chk(int_oe_b, 1'b1);
  endtask
  task automatic test_latch;
    wr(gxp_pkg::PTR_LAT1, 16'h0001, 1);
    p1 = 8'h02;
    w(20);
    p1 = 8'h03;
    w(10);
    chk(int_oe_b, 1'b0);
    rd(gxp_pkg::PTR_IN1, 8'h02);
    rd(gxp_pkg::PTR_IN1, 8'h03);
    w(10);
    chk(int_oe_b, 1'b1);
  endtask
  task automatic test_pad;
    wr(gxp_pkg::PTR_DRV0A, 16'h001b, 1);
    wr(gxp_pkg::PTR_PEN0, 16'h0000, 2);
    wr(gxp_pkg::PTR_PSEL0, 16'h000f, 1);
    chk(pad, {24'hffffff, 8'h1b, 16'h0000, 16'hff0f});
  endtask
  initial begin
    #1;
    do_reset;
    test_regs;
    test_addr;
    test_out;
    test_int;
    test_latch;
    test_pad;
    do_reset;
    rd(gxp_pkg::PTR_OUT0, 8'hff);
    wrap_up;
  end
  // Ceiling well above the roughly 11000 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      wrap_up;
    end
  end
endmodule
